// File: rtl/cfgma_top.sv
// message interpreter for configuration register access
`timescale 1ns/1ps
// Overview of operation
// - write with reply low byte all ones gets no reply at all
// - multi-byte fields travel most significant byte first
// - status resource id is processor status number shifted eight, ORed 0x0b
// - write framing: token 192, reply id, register number, data, token 1
// - write answer: tokens 3,1 on success or 4,1 on failure
// - read answer: token 3, 32-bit data, token 1; or 4,1
module cfgma_top
  import cfgma_pkg::*;
(
  // clock and reset
  input  wire  logic        MCLK,
  input  wire  logic        RSTN,
  // request token stream
  input  wire  logic [7:0]  RX_DATA,
  input  wire  logic        RX_CTL,
  input  wire  logic        RX_VALID,
  output logic              RX_READY,
  // reply token stream
  output logic [7:0]        TX_DATA,
  output logic              TX_CTL,
  output logic              TX_VALID,
  input  wire  logic        TX_READY,
  output logic [23:0]       TX_DEST,
  // register bank access
  output logic [15:0]       REG_NUM,
  output logic [31:0]       REG_WDATA,
  output logic              REG_WE,
  output logic              REG_RE,
  input  wire  logic        REG_HIT,
  input  wire  logic [31:0] REG_RDATA,
  // processor status resource id
  input  wire  logic [7:0]  PS_NUM,
  output logic [15:0]       PS_RES_ID
);

  typedef struct packed {
    cfgma_state_t st;
    logic [1:0]   cnt;
    logic         is_rd;
    logic         bad;
    logic [23:0]  reply;
    logic [23:0]  dest;
    logic [15:0]  num;
    logic [31:0]  wdat;
    logic [31:0]  rdat;
    logic         ok;
    logic [2:0]   step;
    logic         rx_rdy;
    logic         we;
    logic         re;
    logic [15:0]  ps_id;
  } cfgma_st_t;

  cfgma_st_t  r_r;
  cfgma_st_t  r_nxt;
  logic       accept;
  logic       push;
  logic       buf_ready;
  logic [8:0] bval;

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  function automatic logic [2:0] last_step(input logic ok, input logic rd);
    last_step = (ok && rd) ? RD_OK_LAST : SHORT_LAST;
  endfunction

  function automatic logic [8:0] resp_byte(input logic [2:0]  step,
                                           input logic        ok,
                                           input logic        rd,
                                           input logic [31:0] d);
    logic [31:0] sh;
    sh = d >> {3'h4 - step, 3'h0};
    if (step == 3'h0)
      resp_byte = {1'b1, ok ? TOK_OK : TOK_FAIL};
    else if (step == last_step(ok, rd))
      resp_byte = {1'b1, TOK_END};
    else
      resp_byte = {1'b0, sh[7:0]};
  endfunction

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  always_comb
  begin
    r_nxt  = r_r;
    accept = RX_VALID & r_r.rx_rdy;
    bval   = resp_byte(r_r.step, r_r.ok, r_r.is_rd, r_r.rdat);
    push   = (r_r.st == S_RESP) & buf_ready;
    // status id is pure wiring of a number, kept registered for timing
    r_nxt.ps_id = {PS_NUM, PS_RES_LOW};
    r_nxt.we    = 1'b0;
    r_nxt.re    = 1'b0;
    unique case (r_r.st)
      S_IDLE:
      begin
        r_nxt.bad = 1'b0;
        r_nxt.cnt = 2'h0;
        // stray bytes outside a frame have no reply address: dropped
        if (accept && RX_CTL && (RX_DATA == TOK_WR || RX_DATA == TOK_RD))
        begin
          r_nxt.is_rd = (RX_DATA == TOK_RD);
          r_nxt.st    = S_RPLY;
        end
      end
      S_RPLY, S_REGN, S_WDAT:
      begin
        if (accept && RX_CTL)
        begin
          r_nxt.bad = 1'b1;
          r_nxt.st  = (RX_DATA == TOK_END) ? S_CHK : S_END;
        end
        else if (accept)
        begin
          r_nxt.cnt = r_r.cnt + 2'h1;
          if (r_r.st == S_RPLY)
          begin
            r_nxt.reply = {r_r.reply[15:0], RX_DATA};
            if (r_r.cnt == REPLY_LAST)
            begin
              r_nxt.cnt = 2'h0;
              r_nxt.st  = S_REGN;
            end
          end
          else if (r_r.st == S_REGN)
          begin
            r_nxt.num = {r_r.num[7:0], RX_DATA};
            if (r_r.cnt == REGN_LAST)
            begin
              r_nxt.cnt = 2'h0;
              r_nxt.st  = r_r.is_rd ? S_END : S_WDAT;
            end
          end
          else
          begin
            r_nxt.wdat = {r_r.wdat[23:0], RX_DATA};
            if (r_r.cnt == WDAT_LAST)
            begin
              r_nxt.cnt = 2'h0;
              r_nxt.st  = S_END;
            end
          end
        end
      end
      S_END:
      begin
        if (accept && RX_CTL && RX_DATA == TOK_END)
          r_nxt.st = S_CHK;
        else if (accept)
          r_nxt.bad = 1'b1;
      end
      S_CHK:
      begin
        r_nxt.dest = r_r.reply;
        r_nxt.step = 3'h0;
        r_nxt.ok   = 1'b0;
        if (!r_r.bad && REG_HIT)
        begin
          r_nxt.we = ~r_r.is_rd;
          r_nxt.re = r_r.is_rd;
          r_nxt.st = S_STRB;
        end
        else if (!r_r.is_rd && r_r.reply[7:0] == NOREPLY_LOW)
          r_nxt.st = S_IDLE;
        else
          r_nxt.st = S_RESP;
      end
      S_STRB:
      begin
        r_nxt.ok   = 1'b1;
        r_nxt.rdat = REG_RDATA;
        if (!r_r.is_rd && r_r.reply[7:0] == NOREPLY_LOW)
          r_nxt.st = S_IDLE;
        else
          r_nxt.st = S_RESP;
      end
      S_RESP:
      begin
        if (push)
        begin
          r_nxt.step = r_r.step + 3'h1;
          if (r_r.step == last_step(r_r.ok, r_r.is_rd))
          begin
            r_nxt.step = 3'h0;
            r_nxt.st   = S_IDLE;
          end
        end
      end
    endcase
    r_nxt.rx_rdy = (r_nxt.st == S_IDLE) || (r_nxt.st == S_RPLY) ||
                   (r_nxt.st == S_REGN) || (r_nxt.st == S_WDAT) ||
                   (r_nxt.st == S_END);
  end

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      r_r <= '{st: S_IDLE, default: '0};
    else
      r_r <= r_nxt;
  end

  // ---------------------------------------------------------------------
  // reply buffer
  // ---------------------------------------------------------------------
  cfgma_buf #(
    .W (BUF_W),
    .D (BUF_D)
  ) u_buf (
    .MCLK      (MCLK),
    .RSTN      (RSTN),
    .in_data   (bval),
    .in_valid  (r_r.st == S_RESP),
    .in_ready  (buf_ready),
    .out_data  ({TX_CTL, TX_DATA}),
    .out_valid (TX_VALID),
    .out_ready (TX_READY)
  );

  assign RX_READY  = r_r.rx_rdy;
  assign TX_DEST   = r_r.dest;
  assign REG_NUM   = r_r.num;
  assign REG_WDATA = r_r.wdat;
  assign REG_WE    = r_r.we;
  assign REG_RE    = r_r.re;
  assign PS_RES_ID = r_r.ps_id;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RSTN);

  sequence end_pushed;
    push && bval == {1'b1, TOK_END};
  endsequence

  hdr_wr_a:
  assert property (r_r.st == S_IDLE && accept && RX_CTL && RX_DATA == TOK_WR
                   |=> r_r.st == S_RPLY && !r_r.is_rd)
    else $error("write header not taken");

  no_reply_a:
  assert property ((r_r.st == S_CHK || r_r.st == S_STRB) && !r_r.is_rd &&
                   r_r.reply[7:0] == NOREPLY_LOW && !r_r.we
                   |=> (r_r.st != S_RESP)[*6])
    else $error("reply sent for suppressed write");

  ps_id_a:
  assert property (1'b1 |=> PS_RES_ID == {$past(PS_NUM), 8'h0b})
    else $error("status resource id wrong");

  msb_first_a:
  assert property (r_r.st == S_RPLY && accept && !RX_CTL && r_r.cnt == 2'h2
                   |=> r_r.reply[7:0] == $past(RX_DATA) && r_r.st == S_REGN)
    else $error("reply id byte order wrong");

  fail_safe_a:
  assert property (r_r.st == S_CHK && r_r.bad
                   |=> !REG_WE && !REG_RE && r_r.st != S_STRB)
    else $error("malformed request reached the bank");

  wr_answer_a:
  assert property (r_r.st == S_STRB && !r_r.is_rd &&
                   r_r.reply[7:0] != NOREPLY_LOW
                   |=> r_r.ok && bval == {1'b1, TOK_OK} ##[0:60] end_pushed)
    else $error("write answer sequence wrong");

  rd_data_a:
  assert property (push && r_r.ok && r_r.is_rd && r_r.step == 3'h1
                   |-> bval == {1'b0, r_r.rdat[31:24]})
    else $error("read data not msb first");

endmodule

// File: rtl/cfgma_pkg.sv
// constants and types for configuration register message access
package cfgma_pkg;

  // ---------------------------------------------------------------------
  // token values
  // ---------------------------------------------------------------------
  localparam logic [7:0] TOK_WR     = 8'hc0;
  localparam logic [7:0] TOK_RD     = 8'hc1;
  localparam logic [7:0] TOK_END    = 8'h01;
  localparam logic [7:0] TOK_OK     = 8'h03;
  localparam logic [7:0] TOK_FAIL   = 8'h04;

  // ---------------------------------------------------------------------
  // field layout and codes
  // ---------------------------------------------------------------------
  localparam logic [7:0] NOREPLY_LOW = 8'hff;
  localparam logic [7:0] PS_RES_LOW  = 8'h0b;
  localparam logic [1:0] REPLY_LAST  = 2'h2;
  localparam logic [1:0] REGN_LAST   = 2'h1;
  localparam logic [1:0] WDAT_LAST   = 2'h3;
  localparam logic [2:0] RD_OK_LAST  = 3'h5;
  localparam logic [2:0] SHORT_LAST  = 3'h1;
  localparam int         BUF_W       = 9;
  localparam int         BUF_D       = 2;

  // ---------------------------------------------------------------------
  // states
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE,
    S_RPLY,
    S_REGN,
    S_WDAT,
    S_END,
    S_CHK,
    S_STRB,
    S_RESP
  } cfgma_state_t;

endpackage

// File: rtl/cfgma_buf.sv
// two-entry reply buffer with valid and ready on both sides
`timescale 1ns/1ps
module cfgma_buf
  import cfgma_pkg::*;
#(
  parameter int W = BUF_W,
  parameter int D = BUF_D
)
(
  // clock and reset
  input  wire  logic         MCLK,
  input  wire  logic         RSTN,
  // filling side
  input  wire  logic [W-1:0] in_data,
  input  wire  logic         in_valid,
  output logic               in_ready,
  // draining side
  output logic [W-1:0]       out_data,
  output logic               out_valid,
  input  wire  logic         out_ready
);

  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] ent;
    logic [CW-1:0]       cnt;
    logic                ovalid;
    logic                iready;
  } cfgma_buf_t;

  cfgma_buf_t r_r;
  cfgma_buf_t r_nxt;
  logic       pop;
  logic       push;

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  always_comb
  begin
    r_nxt = r_r;
    pop   = r_r.ovalid & out_ready;
    push  = in_valid & r_r.iready;
    if (pop)
    begin
      for (int i = 0; i < D - 1; i++)
      begin
        r_nxt.ent[i] = r_r.ent[i+1];
      end
      r_nxt.cnt = r_nxt.cnt - CW'(1);
    end
    if (push)
    begin
      r_nxt.ent[r_nxt.cnt] = in_data;
      r_nxt.cnt            = r_nxt.cnt + CW'(1);
    end
    // ready and valid are registered so both edges stay flop-driven
    r_nxt.ovalid = (r_nxt.cnt != '0);
    r_nxt.iready = (r_nxt.cnt < CW'(D));
  end

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end

  assign in_ready  = r_r.iready;
  assign out_valid = r_r.ovalid;
  assign out_data  = r_r.ent[0];

endmodule

// File: bench/cfgma_far.sv
// far-side reply sink that can stall the reply stream
`timescale 1ns/1ps
module cfgma_far
(
  // clock and reset
  input  wire logic MCLK,
  input  wire logic RSTN,
  // stall request and reply handshake
  input  wire logic STALL,
  output logic      TX_READY
);
  logic [1:0] cnt_r;

  // ----------------------------------------------------------------
  // ready one cycle in four while stalling, to back up the buffer
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      cnt_r    <= 2'h0;
      TX_READY <= 1'b0;
    end
    else
    begin
      cnt_r    <= cnt_r + 2'h1;
      TX_READY <= !STALL || (cnt_r == 2'h3);
    end
  end
endmodule

// File: bench/test_cfgma_top.sv
// self-checking bench for the configuration message interpreter
`timescale 1ns/1ps
module test_cfgma_top
  import cfgma_pkg::*;
;
  logic MCLK, RSTN, RX_CTL, RX_VALID, RX_READY, TX_CTL, TX_VALID;
  logic TX_READY, REG_WE, REG_RE, REG_HIT, STALL;
  logic [7:0] RX_DATA, TX_DATA, PS_NUM;
  logic [15:0] REG_NUM, PS_RES_ID;
  logic [23:0] TX_DEST;
  logic [31:0] REG_WDATA, REG_RDATA;
  logic [31:0] bank [16];
  logic [8:0] q [$];
  int bad_count, cmp_count, we_cnt, re_cnt, cyc;
  // requester's own channel-end destinations; routing only, unseen here
  localparam logic [15:0] TILE_EP_LOW = 16'hc200;
  // node endpoint code, set per integration
  localparam logic [15:0] NODE_EP_LOW = 16'h0000;

  // ----------------------------------------------------------------
  // clock, bank model, collector, time limit
  // ----------------------------------------------------------------
  initial
  begin
    MCLK = 1'b0;
    forever #50 MCLK = ~MCLK;
  end
  // sixteen implemented registers only
  assign REG_HIT   = (REG_NUM[15:4] == 12'h000);
  assign REG_RDATA = bank[REG_NUM[3:0]];
  always @(posedge MCLK)
  begin
    cyc++;
    if (REG_WE)
    begin
      bank[REG_NUM[3:0]] <= REG_WDATA;
      we_cnt++;
    end
    if (REG_RE)
      re_cnt++;
    if (TX_VALID && TX_READY)
      q.push_back({TX_CTL, TX_DATA});
    if (cyc == 6000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  cfgma_top dut_u (.MCLK(MCLK), .RSTN(RSTN), .RX_DATA(RX_DATA),
    .RX_CTL(RX_CTL), .RX_VALID(RX_VALID), .RX_READY(RX_READY),
    .TX_DATA(TX_DATA), .TX_CTL(TX_CTL), .TX_VALID(TX_VALID),
    .TX_READY(TX_READY), .TX_DEST(TX_DEST), .REG_NUM(REG_NUM),
    .REG_WDATA(REG_WDATA), .REG_WE(REG_WE), .REG_RE(REG_RE),
    .REG_HIT(REG_HIT), .REG_RDATA(REG_RDATA), .PS_NUM(PS_NUM),
    .PS_RES_ID(PS_RES_ID));
  cfgma_far far_u (.MCLK(MCLK), .RSTN(RSTN), .STALL(STALL),
    .TX_READY(TX_READY));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: %s seen %h expected %h", $time, what,
        seen, exp);
    end
  endtask

  // offer one byte and hold it until taken
  task automatic put(input logic c, input logic [7:0] b);
    RX_CTL   <= c;
    RX_DATA  <= b;
    RX_VALID <= 1'b1;
    do @(posedge MCLK); while (RX_READY !== 1'b1);
  endtask

  // reply id and register number always lead, msb first
  task automatic head(input logic [7:0] t, input logic [23:0] rp,
                      input logic [15:0] rn);
    put(1'b1, t);
    for (int i = 2; i >= 0; i--) put(1'b0, rp[i*8 +: 8]);
    for (int i = 1; i >= 0; i--) put(1'b0, rn[i*8 +: 8]);
  endtask

  task automatic wr(input logic [23:0] rp, input logic [15:0] rn,
                    input logic [31:0] d, input int nd);
    head(TOK_WR, rp, rn);
    for (int i = 3; i >= 4 - nd; i--) put(1'b0, d[i*8 +: 8]);
    put(1'b1, TOK_END);
    RX_VALID <= 1'b0;
  endtask

  task automatic rd(input logic [23:0] rp, input logic [15:0] rn);
    head(TOK_RD, rp, rn);
    put(1'b1, TOK_END);
    RX_VALID <= 1'b0;
  endtask

  // wait for n reply entries, left-aligned in exp, then compare
  task automatic reply(input int n, input logic [53:0] exp);
    int k;
    k = 0;
    while (q.size() < n && k < 300)
    begin
      @(posedge MCLK);
      k++;
    end
    chk(q.size(), n, "reply length");
    for (int i = 0; i < n && q.size() > 0; i++)
      chk(q.pop_front(), exp[53-9*i -: 9], "reply entry");
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_write_ok;
    wr(24'h12a5c2, 16'h0003, 32'hdeadbe01, 4);
    reply(2, {1'b1, TOK_OK, 1'b1, TOK_END, 36'h0});
    chk(bank[3], 32'hdeadbe01, "written word");
    chk(TX_DEST, 24'h12a5c2, "reply dest");
    $display("test write ok done");
  endtask

  task automatic t_read_stall;
    int r0;
    r0 = re_cnt;
    STALL <= 1'b1;
    rd(24'h0001c2, 16'h0003);
    reply(6, {1'b1, TOK_OK, 1'b0, 8'hde, 1'b0, 8'had, 1'b0, 8'hbe,
              1'b0, 8'h01, 1'b1, TOK_END});
    chk(re_cnt, r0 + 1, "read strobes");
    STALL <= 1'b0;
    $display("test read stalled done");
  endtask

  task automatic t_fail;
    int w0;
    int r0;
    w0 = we_cnt;
    r0 = re_cnt;
    wr(24'h0002c2, 16'h0100, 32'h11111111, 4);
    reply(2, {1'b1, TOK_FAIL, 1'b1, TOK_END, 36'h0});
    wr(24'h0002c2, 16'h0003, 32'h22222222, 2);
    reply(2, {1'b1, TOK_FAIL, 1'b1, TOK_END, 36'h0});
    // stray token inside the data field, then data before the close
    head(TOK_WR, 24'h0002c2, 16'h0003);
    put(1'b1, 8'h02);
    put(1'b0, 8'h77);
    put(1'b1, TOK_END);
    RX_VALID <= 1'b0;
    reply(2, {1'b1, TOK_FAIL, 1'b1, TOK_END, 36'h0});
    rd(24'h0002c2, 16'h0100);
    reply(2, {1'b1, TOK_FAIL, 1'b1, TOK_END, 36'h0});
    chk(we_cnt, w0, "strobes on failure");
    chk(re_cnt, r0, "reads on failure");
    chk(bank[3], 32'hdeadbe01, "word kept");
    $display("test failures done");
  endtask

  task automatic t_silent;
    wr(24'h0003ff, 16'h0005, 32'h0badf00d, 4);
    repeat (30) @(posedge MCLK);
    chk(q.size(), 0, "suppressed reply");
    chk(bank[5], 32'h0badf00d, "silent write");
    $display("test suppressed reply done");
  endtask

  task automatic t_status;
    logic [7:0] v [3] = '{8'h00, 8'h5a, 8'hff};
    foreach (v[i])
    begin
      PS_NUM <= v[i];
      repeat (2) @(posedge MCLK);
      chk(PS_RES_ID, {v[i], 8'h0b}, "status id");
    end
    $display("test status id done");
  endtask

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    RSTN = 1'b0;
    RX_DATA = 8'h00;
    RX_CTL = 1'b0;
    RX_VALID = 1'b0;
    PS_NUM = 8'h00;
    STALL = 1'b0;
    foreach (bank[i]) bank[i] = 32'h0;
    repeat (4) @(posedge MCLK);
    RSTN <= 1'b1;
    @(posedge MCLK);
    t_write_ok();
    t_read_stall();
    t_fail();
    t_silent();
    t_status();
    give_verdict();
  end
endmodule
